// ===== pkg/fprc_pkg.sv
// constants and types of the flash protection and reset controller
// assumes a 100 MHz core clock and an 8-Mbyte array
package fprc_pkg;
  // ****************
  // opcodes and framing
  // ****************
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PROG  = 8'h02;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [2:0] NB_MAX      = 3'h7;
  localparam logic [2:0] NB_OP       = 3'h0;
  localparam logic [2:0] NB_SR       = 3'h1;
  localparam logic [2:0] NB_ADDR_END = 3'h3;
  localparam logic [2:0] SR_BYTES    = 3'h2;
  localparam logic [2:0] ERASE_BYTES = 3'h4;
  localparam logic [2:0] PROG_BYTES  = 3'h5;
  // ****************
  // array and protection decode
  // ****************
  localparam int         ADDR_W     = 23;
  localparam int         BLK_SHIFT  = 12;
  localparam logic [2:0] BP_NONE    = 3'h0;
  localparam logic [2:0] BP_ALL     = 3'h7;
  localparam logic [4:0] BIG_SH     = 5'h10;
  localparam logic [4:0] SEC_SH     = 5'h0B;
  localparam logic [4:0] SEC_MAX_SH = 5'h0F;
  localparam int SR_BP_LSB = 0;
  localparam int SR_TB     = 3;
  localparam int SR_SEC    = 4;
  localparam int SR_CMP    = 5;
  typedef struct packed {
    logic       range_complement;
    logic       sector_granularity;
    logic       top_bottom_select;
    logic [2:0] block_protect;
  } fprc_prot_t;
  // ****************
  // registers
  // ****************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_CHECK  = 8'h08;
  localparam int ST_WEL      = 0;
  localparam int ST_ARMED    = 1;
  localparam int ST_BUSY     = 2;
  localparam int ST_WP       = 3;
  localparam int ST_REFUSED  = 4;
  localparam int ST_PROT_LSB = 8;
  localparam int CTRL_XIP_LSB  = 0;
  localparam int CTRL_WRAP_LSB = 8;
  localparam int CTRL_HALT     = 11;
  localparam int CHECK_HIT     = 31;
  // ****************
  // timing
  // ****************
  localparam int CLK_MHZ     = 100;
  localparam int RST_TIME_NS = 30000;
  localparam int RST_CYC     = RST_TIME_NS * CLK_MHZ / 1000;
endpackage

// ===== pkg/fprc_range_if.sv
// protection settings and an address in, protected flag out
// assumes a combinational decoder on the dec side
interface fprc_range_if;
  fprc_pkg::fprc_prot_t              prot;
  logic [fprc_pkg::ADDR_W-1:0]       addr;
  logic                              hit;
  modport dec  (input prot, input addr, output hit);
  modport user (output prot, output addr, input hit);
endinterface

// ===== rtl/fprc_range_dec.sv
// decodes the protection fields into a protected flag for one address
// assumes settings and address are stable register outputs
module fprc_range_dec (
  fprc_range_if.dec rif  // settings, address and result
);
  localparam int AW = fprc_pkg::ADDR_W;
  logic [AW:0] size;
  logic [AW:0] full;
  logic [4:0]  sh;
  logic        in_rng;

  always_comb begin
    full = (AW+1)'(1) << AW;
    // granularity mode tops out at 32 kbytes for codes 10x and 110
    if (rif.prot.sector_granularity) begin
      sh = rif.prot.block_protect[2] ? fprc_pkg::SEC_MAX_SH
                                     : fprc_pkg::SEC_SH + 5'(rif.prot.block_protect);
    end else begin
      sh = fprc_pkg::BIG_SH + 5'(rif.prot.block_protect);
    end
    size = (AW+1)'(1) << sh;
    if (rif.prot.block_protect == fprc_pkg::BP_NONE) begin
      in_rng = 1'b0;
    end else if (rif.prot.block_protect == fprc_pkg::BP_ALL) begin
      in_rng = 1'b1;
    end else if (rif.prot.top_bottom_select) begin
      in_rng = {1'b0, rif.addr} < size;
    end else begin
      in_rng = {1'b0, rif.addr} >= full - size;
    end
    rif.hit = in_rng ^ rif.prot.range_complement;
  end
endmodule

// ===== rtl/fprc_top.sv
// flash protection decode, status-write gating and software reset sequencing
// assumes SPI mode 0 pins from the host and an APB master on clk
module fprc_top #(
  parameter int RST_CYC = fprc_pkg::RST_CYC
) (
  input  wire logic        clk,            // 100 MHz core clock
  input  wire logic        nrst,           // synchronous reset, low
  input  wire logic        sck,            // serial clock pin
  input  wire logic        cs_n,           // chip select pin, low
  input  wire logic        mosi,           // serial data in pin
  input  wire logic        wp_n,           // write-protect pin, low
  input  wire logic [7:0]  paddr,          // apb address
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             prog_go,        // program accepted pulse
  output logic             erase_go,       // erase accepted pulse
  output logic      [22:0] op_addr,        // target of accepted operation
  output logic             abort_ops,      // abort internal operations pulse
  output logic             reset_busy      // reset in progress
);
  localparam int CNT_W = $clog2(RST_CYC + 1);

  if (RST_CYC < 2 || RST_CYC > 4096) begin : g_bad_cyc
    $error("RST_CYC out of range");
  end

  typedef struct packed {
    logic                 sck_m;
    logic                 sck_s;
    logic                 sck_p;
    logic                 cs_m;
    logic                 cs_s;
    logic                 cs_p;
    logic                 mosi_m;
    logic                 mosi_s;
    logic                 wp_m;
    logic                 wp_s;
    logic [7:0]           sh;
    logic [2:0]           bits;
    logic [2:0]           nbytes;
    logic [7:0]           op;
    logic [7:0]           sr;
    logic [23:0]          addr;
    fprc_pkg::fprc_prot_t prot;
    logic                 write_enable_latch;
    logic                 armed;
    logic                 busy;
    logic [CNT_W-1:0]     cnt;
    logic                 refused;
    logic [7:0]           xip_mode_bits;
    logic [2:0]           burst_wrap_bits;
    logic                 halted_op_flag;
    logic [22:0]          chk;
    logic                 prog_go;
    logic                 erase_go;
    logic                 abort;
    logic [22:0]          op_addr;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
  } fprc_st_t;

  fprc_st_t     q;
  fprc_st_t     d;
  logic         frame_end;
  logic         apb_wr;
  logic [7:0]   sh_n;
  fprc_range_if op_if ();
  fprc_range_if chk_if ();

  // ****************
  // range decoders
  // ****************
  // a whole 4-kbyte block shares one protection state, so its base decides
  assign op_if.prot  = q.prot;
  assign op_if.addr  = {q.addr[22:fprc_pkg::BLK_SHIFT], {fprc_pkg::BLK_SHIFT{1'b0}}};
  assign chk_if.prot = q.prot;
  assign chk_if.addr = q.chk;

  fprc_range_dec u_op_dec (
    .rif (op_if.dec)
  );

  fprc_range_dec u_chk_dec (
    .rif (chk_if.dec)
  );

  // ****************
  // next state
  // ****************
  always_comb begin
    d        = q;
    sh_n     = {q.sh[6:0], q.mosi_s};
    d.sck_m  = sck;
    d.sck_s  = q.sck_m;
    d.sck_p  = q.sck_s;
    d.cs_m   = cs_n;
    d.cs_s   = q.cs_m;
    d.cs_p   = q.cs_s;
    d.mosi_m = mosi;
    d.mosi_s = q.mosi_m;
    d.wp_m   = wp_n;
    d.wp_s   = q.wp_m;
    d.prog_go  = 1'b0;
    d.erase_go = 1'b0;
    d.abort    = 1'b0;

    // serial shifter, mode 0: data taken on rising sck
    if (q.cs_s) begin
      d.bits   = '0;
      d.nbytes = '0;
    end else if (q.sck_s && !q.sck_p) begin
      d.sh   = sh_n;
      d.bits = q.bits + 3'h1;
      if (q.bits == fprc_pkg::BIT_LAST) begin
        if (q.nbytes != fprc_pkg::NB_MAX) begin
          d.nbytes = q.nbytes + 3'h1;
        end
        if (q.nbytes == fprc_pkg::NB_OP) begin
          d.op = sh_n;
        end
        if (q.nbytes == fprc_pkg::NB_SR) begin
          d.sr = sh_n;
        end
        if (q.nbytes != fprc_pkg::NB_OP && q.nbytes <= fprc_pkg::NB_ADDR_END) begin
          d.addr = {q.addr[15:0], sh_n};
        end
      end
    end

    // reset interval countdown
    if (q.busy) begin
      if (q.cnt == '0) begin
        d.busy = 1'b0;
      end else begin
        d.cnt = q.cnt - CNT_W'(1);
      end
    end

    // apb: one wait state, then the answer stands for one cycle
    d.pready = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.prdata  = '0;
      case (paddr)
        fprc_pkg::REG_STATUS: begin
          d.prdata[fprc_pkg::ST_WEL]     = q.write_enable_latch;
          d.prdata[fprc_pkg::ST_ARMED]   = q.armed;
          d.prdata[fprc_pkg::ST_BUSY]    = q.busy;
          d.prdata[fprc_pkg::ST_WP]      = q.wp_s;
          d.prdata[fprc_pkg::ST_REFUSED] = q.refused;
          d.prdata[fprc_pkg::ST_PROT_LSB +: 6] = q.prot;
        end
        fprc_pkg::REG_CTRL: begin
          d.prdata[fprc_pkg::CTRL_XIP_LSB +: 8]  = q.xip_mode_bits;
          d.prdata[fprc_pkg::CTRL_WRAP_LSB +: 3] = q.burst_wrap_bits;
          d.prdata[fprc_pkg::CTRL_HALT]          = q.halted_op_flag;
        end
        fprc_pkg::REG_CHECK: begin
          d.prdata[22:0]                 = q.chk;
          d.prdata[fprc_pkg::CHECK_HIT]  = chk_if.hit;
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end
    apb_wr = psel && penable && q.pready && pwrite && !q.pslverr;
    if (apb_wr) begin
      case (paddr)
        fprc_pkg::REG_STATUS: begin
          if (pwdata[fprc_pkg::ST_REFUSED]) begin
            d.refused = 1'b0;
          end
        end
        fprc_pkg::REG_CTRL: begin
          d.xip_mode_bits   = pwdata[fprc_pkg::CTRL_XIP_LSB +: 8];
          d.burst_wrap_bits = pwdata[fprc_pkg::CTRL_WRAP_LSB +: 3];
          d.halted_op_flag  = pwdata[fprc_pkg::CTRL_HALT];
        end
        fprc_pkg::REG_CHECK: begin
          d.chk = pwdata[22:0];
        end
        default: begin
        end
      endcase
    end

    // command completion on chip select release; placed after the apb
    // write so a refusal in the same cycle as a clear is kept
    frame_end = q.cs_s && !q.cs_p && !q.busy
                && q.nbytes != fprc_pkg::NB_OP && q.bits == '0;
    if (frame_end) begin
      d.armed = (q.op == fprc_pkg::OP_RSTEN);
      case (q.op)
        fprc_pkg::OP_RST: begin
          if (q.armed) begin
            d.busy               = 1'b1;
            d.cnt                = CNT_W'(RST_CYC - 1);
            d.abort              = 1'b1;
            d.write_enable_latch = 1'b0;
            d.xip_mode_bits      = '0;
            d.burst_wrap_bits    = '0;
            d.halted_op_flag     = 1'b0;
          end
        end
        fprc_pkg::OP_WREN: begin
          d.write_enable_latch = 1'b1;
        end
        fprc_pkg::OP_WRDI: begin
          d.write_enable_latch = 1'b0;
        end
        fprc_pkg::OP_WRSR: begin
          if (q.write_enable_latch && q.nbytes >= fprc_pkg::SR_BYTES) begin
            if (!q.wp_s) begin
              d.refused = 1'b1;
            end else begin
              d.prot.range_complement   = q.sr[fprc_pkg::SR_CMP];
              d.prot.sector_granularity = q.sr[fprc_pkg::SR_SEC];
              d.prot.top_bottom_select  = q.sr[fprc_pkg::SR_TB];
              d.prot.block_protect      = q.sr[fprc_pkg::SR_BP_LSB +: 3];
              d.write_enable_latch      = 1'b0;
            end
          end
        end
        fprc_pkg::OP_PROG: begin
          if (q.write_enable_latch && q.nbytes >= fprc_pkg::PROG_BYTES) begin
            d.write_enable_latch = 1'b0;
            if (op_if.hit) begin
              d.refused = 1'b1;
            end else begin
              d.prog_go = 1'b1;
              d.op_addr = q.addr[22:0];
            end
          end
        end
        fprc_pkg::OP_ERASE: begin
          if (q.write_enable_latch && q.nbytes == fprc_pkg::ERASE_BYTES) begin
            d.write_enable_latch = 1'b0;
            if (op_if.hit) begin
              d.refused = 1'b1;
            end else begin
              d.erase_go = 1'b1;
              d.op_addr  = op_if.addr;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q      <= '0;
      // chip select idles high; a zero here would fake a release edge
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.cs_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign prog_go    = q.prog_go;
  assign erase_go   = q.erase_go;
  assign op_addr    = q.op_addr;
  assign abort_ops  = q.abort;
  assign reset_busy = q.busy;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_wel_gate: assert property ((q.prog_go || q.erase_go) |-> $past(q.write_enable_latch))
    else $error("operation started without write enable");
  a_no_prot_op: assert property ((q.prog_go || q.erase_go) |-> !$past(op_if.hit))
    else $error("operation started on protected address");
  a_erase_refuse: assert property ((frame_end && q.op == fprc_pkg::OP_ERASE
      && q.write_enable_latch && q.nbytes == fprc_pkg::ERASE_BYTES && op_if.hit)
      |=> !q.write_enable_latch && !q.erase_go)
    else $error("protected erase not refused");
  a_wp_lock: assert property ($changed(q.prot) |-> $past(q.wp_s))
    else $error("protection changed while write-protect low");
  a_arm_first: assert property ($rose(q.busy) |-> $past(q.armed)
      && $past(q.op) == fprc_pkg::OP_RST)
    else $error("reset without armed enable-reset");
  a_rst_clear: assert property ($rose(q.busy) |-> q.abort && !q.write_enable_latch
      && q.xip_mode_bits == '0 && q.burst_wrap_bits == '0 && !q.halted_op_flag
      ##1 !q.abort)
    else $error("reset left volatile state");
  a_rst_len: assert property ($rose(q.busy) |-> q.cnt == CNT_W'(RST_CYC - 1))
    else $error("reset interval wrong");
  a_busy_end: assert property ((q.busy && q.cnt == '0) |=> !q.busy)
    else $error("reset interval overran");
  a_busy_mute: assert property ($past(q.busy) |-> !q.prog_go && !q.erase_go)
    else $error("command accepted during reset");
  a_odd_cut: assert property ((q.cs_s && !q.cs_p && q.bits != '0)
      |=> $stable(q.write_enable_latch) && !$rose(q.busy))
    else $error("partial byte command acted");
  a_full_code: assert property ((q.prot.block_protect == fprc_pkg::BP_ALL)
      |-> chk_if.hit == !q.prot.range_complement)
    else $error("code 111 decode wrong");
  a_top_64: assert property ((q.prot == 6'h01) |-> chk_if.hit == (q.chk >= 23'h7E0000))
    else $error("upper 1/64 decode wrong");

  c_reset: cover property ($rose(q.busy));
  c_prog: cover property (q.prog_go);
  c_erase: cover property (q.erase_go);
  c_refused: cover property ($rose(q.refused));
endmodule

// ===== tb/fprc_spi_host.sv
// spi mode 0 host model that sends command frames to the flash block
// assumes the block samples the pins on its own clock
module fprc_spi_host (
  input  wire logic clk,   // core clock that paces the link
  output logic      sck,   // serial clock, still low between frames
  output logic      cs_n,  // chip select, low during a frame
  output logic      mosi   // serial data, msb first
);
  timeunit 1ns;
  timeprecision 100ps;
  // half of the 80 ns link period in core cycles
  localparam int HALF = 4;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // the n low bits of d go out msb first
  task automatic frame(input logic [39:0] d, input int n);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= d[i];
      repeat (HALF) @(posedge clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    // released line must not keep showing the last bit
    mosi <= ~mosi;
    // gap long enough for the block to act on the frame
    repeat (12) @(posedge clk);
  endtask
endmodule

// ===== tb/tb.sv
// self-checking bench: apb register access plus spi command frames
// assumes a 100 MHz clock and a short reset time parameter
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RCYC = 200;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wp_n = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, prog_go, erase_go, abort_ops, reset_busy;
  logic        sck, cs_n, mosi, err;
  logic [22:0] op_addr, la;
  logic [31:0] r;
  logic [5:0]  cur = 6'h00;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n_er = 0, n_pg = 0, n_ab = 0, blen = 0;
  logic [29:0] tbl [27];
  always #5 clk = ~clk;
  fprc_top #(.RST_CYC(RCYC)) dut (
    .clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_go(prog_go),
    .erase_go(erase_go), .op_addr(op_addr), .abort_ops(abort_ops),
    .reset_busy(reset_busy)
  );
  fprc_spi_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  always @(posedge clk) begin
    if (erase_go === 1'b1) begin
      n_er++;
      la = op_addr;
    end
    if (prog_go === 1'b1) begin
      n_pg++;
      la = op_addr;
    end
    if (abort_ops === 1'b1) n_ab++;
    if (reset_busy === 1'b1) blen++;
  end
  // ****************
  // helpers
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 100);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask
  function automatic logic [31:0] st(input logic [5:0] p, input logic [4:0] f);
    return {18'h0, p, 3'h0, f};
  endfunction
  task automatic stat_is(input logic [5:0] p, input logic [4:0] f);
    apb(1'b0, fprc_pkg::REG_STATUS, 32'h0);
    chk("status", r, st(p, f));
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame(40'(op), 8);
  endtask
  task automatic set_prot(input logic [5:0] p);
    cmd(fprc_pkg::OP_WREN);
    host.frame(40'({fprc_pkg::OP_WRSR, 2'b00, p}), 16);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #500us;
    n_mismatch++;
    $display("unexpected watchdog: expected end seen hang");
    wrap_up();
  end
  // ****************
  // tests
  // ****************
  initial begin
    // {prot, address, protected}
    tbl = '{{6'h00, 23'h7FFFFF, 1'b0}, {6'h07, 23'h000000, 1'b1},
            {6'h1F, 23'h400000, 1'b1}, {6'h01, 23'h7E0000, 1'b1},
            {6'h01, 23'h7DFFFF, 1'b0}, {6'h06, 23'h400000, 1'b1},
            {6'h06, 23'h3FFFFF, 1'b0}, {6'h09, 23'h01FFFF, 1'b1},
            {6'h09, 23'h020000, 1'b0}, {6'h0A, 23'h03FFFF, 1'b1},
            {6'h0A, 23'h040000, 1'b0}, {6'h0E, 23'h3FFFFF, 1'b1},
            {6'h0E, 23'h400000, 1'b0}, {6'h11, 23'h7FF000, 1'b1},
            {6'h11, 23'h7FEFFF, 1'b0}, {6'h14, 23'h7F8000, 1'b1},
            {6'h14, 23'h7F7FFF, 1'b0}, {6'h15, 23'h7F8000, 1'b1},
            {6'h19, 23'h000FFF, 1'b1}, {6'h19, 23'h001000, 1'b0},
            {6'h1D, 23'h007FFF, 1'b1}, {6'h1D, 23'h008000, 1'b0},
            {6'h20, 23'h123456, 1'b1}, {6'h27, 23'h000000, 1'b0},
            {6'h21, 23'h7E0000, 1'b0}, {6'h21, 23'h7DFFFF, 1'b1},
            {6'h3B, 23'h003FFF, 1'b0}};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    stat_is(6'h00, 5'b01000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", {err, r[30:0]}, 32'h80000000);
    apb(1'b1, fprc_pkg::REG_CTRL, 32'hFFF);
    apb(1'b0, fprc_pkg::REG_CTRL, 32'h0);
    chk("ctrl", r, 32'hFFF);
    host.frame(40'({fprc_pkg::OP_WRSR, 8'h07}), 16);
    apb(1'b0, fprc_pkg::REG_STATUS, 32'h0);
    chk("prot no latch", r & 32'h3F00, 32'h0);
    $display("test access done");
    for (int i = 0; i < 27; i++) begin
      if (tbl[i][29:24] !== cur) begin
        set_prot(tbl[i][29:24]);
        cur = tbl[i][29:24];
      end
      apb(1'b1, fprc_pkg::REG_CHECK, {9'h0, tbl[i][23:1]});
      apb(1'b0, fprc_pkg::REG_CHECK, 32'h0);
      chk("hit", {31'h0, r[31]},
          {31'h0, tbl[i][0]});
    end
    $display("test decode done");
    @(posedge clk) wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    set_prot(6'h01);
    stat_is(6'h3B, 5'b10001);
    apb(1'b1, fprc_pkg::REG_STATUS, 32'h10);
    stat_is(6'h3B, 5'b00001);
    @(posedge clk) wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    set_prot(6'h01);
    stat_is(6'h01, 5'b01000);
    $display("test lock done");
    host.frame(40'({fprc_pkg::OP_ERASE, 24'h123456}), 32);
    chk("erase no latch", n_er, 0);
    cmd(fprc_pkg::OP_WREN);
    host.frame(40'({fprc_pkg::OP_ERASE, 24'h7E1234}), 32);
    chk("erase prot", n_er, 0);
    stat_is(6'h01, 5'b11000);
    apb(1'b1, fprc_pkg::REG_STATUS, 32'h10);
    cmd(fprc_pkg::OP_WREN);
    host.frame(40'({fprc_pkg::OP_ERASE, 24'h123456}), 32);
    chk("erase go", n_er, 1);
    chk("erase addr", {9'h0, la}, 32'h123000);
    cmd(fprc_pkg::OP_WREN);
    host.frame({fprc_pkg::OP_PROG, 24'h000010, 8'hA5}, 40);
    chk("prog go", n_pg, 1);
    chk("prog addr", {9'h0, la}, 32'h000010);
    host.frame(40'(fprc_pkg::OP_WREN), 7);
    stat_is(6'h01, 5'b01000);
    $display("test ops done");
    cmd(fprc_pkg::OP_WREN);
    stat_is(6'h01, 5'b01001);
    cmd(fprc_pkg::OP_RSTEN);
    stat_is(6'h01, 5'b01011);
    cmd(fprc_pkg::OP_WRDI);
    cmd(fprc_pkg::OP_RST);
    chk("abort cancelled", n_ab, 0);
    stat_is(6'h01, 5'b01000);
    cmd(fprc_pkg::OP_WREN);
    cmd(fprc_pkg::OP_RSTEN);
    cmd(fprc_pkg::OP_RST);
    // lands while the reset is still running and must be ignored
    cmd(fprc_pkg::OP_WREN);
    for (int t = 0; t < 500; t++) begin
      apb(1'b0, fprc_pkg::REG_STATUS, 32'h0);
      if (r[2] === 1'b0) break;
    end
    chk("abort", n_ab, 1);
    // the interval is exactly the parameter count of core cycles
    chk("busy length", blen, RCYC);
    stat_is(6'h01, 5'b01000);
    apb(1'b0, fprc_pkg::REG_CTRL, 32'h0);
    chk("ctrl after reset", r, 32'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule
